// ### ift_pkg.sv
package ift_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CYCLE_CLOCKS = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam int BITSEL_LSB = 9;
  localparam int CALL_FAST_BIT = 8;
  localparam int RET_FAST_BIT = 0;
  localparam int TBL_WRITE_BIT = 2;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // ****************************************************************
  // Opcode patterns
  // ****************************************************************
  localparam logic [3:0] OP_MOVE_FF = 4'hc;
  localparam logic [3:0] OP_REL_JUMP = 4'hd;
  localparam logic [3:0] OP_BIT_FIRST = 4'h7;
  localparam logic [3:0] OP_BIT_LAST = 4'hb;
  localparam logic [3:0] OP_BIT_SKIP_SET = 4'ha;
  localparam logic [3:0] OP_BIT_SKIP_CLR = 4'hb;
  localparam logic [7:0] OP_GOTO = 8'hef;
  localparam logic [6:0] OP_CALL = 7'h76;
  localparam logic [9:0] OP_LOAD_PTR = 10'h3b8;
  localparam logic [4:0] OP_COND_BRANCH = 5'h1c;
  localparam logic [4:0] OP_LITERAL = 5'h01;
  localparam logic [7:0] OP_LIT_RETURN = 8'h0c;
  localparam logic [7:0] OP_SET_BANK = 8'h01;
  localparam logic [7:0] OP_MISC = 8'h00;
  localparam logic [14:0] OP_RETURN = 15'h0009;
  localparam logic [14:0] OP_RET_INT = 15'h0008;
  localparam logic [11:0] OP_TABLE = 12'h000;
  localparam logic [4:0] OP_CMP_SKIP = 5'h0c;
  localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
  localparam logic [5:0] OP_INC_SKIP = 6'h0f;
  localparam logic [5:0] OP_INC_SKIPNZ = 6'h12;
  localparam logic [5:0] OP_DEC_SKIPNZ = 6'h13;
  localparam logic [5:0] OP_EXT = 6'h3a;
  localparam logic [7:0] OP_EXT_MOVE = 8'heb;
  localparam logic [7:0] OP_EXT_PTR_LO = 8'he8;
  localparam logic [7:0] OP_EXT_PTR_HI = 8'he9;
  localparam logic [15:0] OP_EXT_CALLW = 16'h0014;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    IFT_CLASS_NOP,
    IFT_CLASS_BYTE,
    IFT_CLASS_BIT,
    IFT_CLASS_LITERAL,
    IFT_CLASS_CONTROL
  } ift_class_t;

  typedef enum logic [1:0] {
    IFT_EXEC,
    IFT_WORD2,
    IFT_SKIP,
    IFT_FLUSH
  } ift_state_t;

endpackage : ift_pkg

// ### ift_decoder.sv
`timescale 1ns/100ps
module ift_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fetch path
  input wire logic [15:0] instr_word,
  output logic fetch_take,
  // Datapath feedback and option
  input wire logic cond_true,
  input wire logic ext_enable,
  // Cycle timing
  output logic [1:0] phase,
  output logic cycle_end,
  output logic exec_valid,
  output logic nop_cycle,
  output logic discard_cycle,
  // Decoded instruction
  output ift_pkg::ift_class_t op_class,
  output logic [15:0] op_word,
  output logic two_word,
  output logic instr_known,
  output logic is_conditional,
  output logic changes_pc,
  // Operand fields
  output logic dest_file,
  output logic bank_from_bsr,
  output logic [2:0] bit_sel,
  output logic [7:0] bit_mask,
  output logic [7:0] file_addr,
  output logic [7:0] literal,
  output logic [1:0] pointer_sel,
  output logic fast_mode,
  output logic table_write,
  output logic [1:0] table_mode,
  output logic [19:0] long_operand,
  output logic [11:0] dest_addr
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [1:0] q;
  logic [15:0] ir;
  // Holds only the second half of a pair, never a word that executes
  logic [15:0] ir2;
  ift_pkg::ift_state_t state;
  ift_pkg::ift_state_t next_state;

  // ****************************************************************
  // Phase counter
  // ****************************************************************
  logic q_last;
  assign q_last = (q == ift_pkg::PHASE_LAST);

  // Free-running from reset, so the first fetch is three edges after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= 2'h0;
    end else begin
      q <= q + 2'h1;
    end
  end

  // ****************************************************************
  // Opcode decode
  // ****************************************************************
  // Six-bit prefix match shared by the skip and extended decodes
  function automatic logic ift_top6(input logic [15:0] w,
                                    input logic [5:0] p);
    return (w[15:10] == p);
  endfunction : ift_top6

  wire [3:0] op4 = ir[15:12];
  wire w_second = (op4 == ift_pkg::SECOND_WORD_TAG);
  wire w_movff = (op4 == ift_pkg::OP_MOVE_FF);
  wire w_goto = (ir[15:8] == ift_pkg::OP_GOTO);
  wire w_call = (ir[15:9] == ift_pkg::OP_CALL);
  wire w_lfsr = (ir[15:6] == ift_pkg::OP_LOAD_PTR);
  wire w_ext_blk = ift_top6(ir, ift_pkg::OP_EXT);
  wire w_ext_mov = (ir[15:8] == ift_pkg::OP_EXT_MOVE);
  wire w_callw = (ir == ift_pkg::OP_EXT_CALLW);
  wire w_ext_ptr = (ir[15:8] == ift_pkg::OP_EXT_PTR_LO) ||
                   (ir[15:8] == ift_pkg::OP_EXT_PTR_HI);
  wire w_ext = w_ext_blk || w_callw;
  wire w_misc = (ir[15:8] == ift_pkg::OP_MISC);
  wire w_return = (ir[15:1] == ift_pkg::OP_RETURN);
  wire w_retfie = (ir[15:1] == ift_pkg::OP_RET_INT);
  wire w_table = (ir[15:4] == ift_pkg::OP_TABLE) && ir[3];
  wire w_retlw = (ir[15:8] == ift_pkg::OP_LIT_RETURN);
  wire w_movlb = (ir[15:8] == ift_pkg::OP_SET_BANK);
  wire w_litop = (ir[15:11] == ift_pkg::OP_LITERAL);
  wire w_rel = (op4 == ift_pkg::OP_REL_JUMP);
  wire w_bcond = (ir[15:11] == ift_pkg::OP_COND_BRANCH);
  wire w_bit = (op4 >= ift_pkg::OP_BIT_FIRST) &&
               (op4 <= ift_pkg::OP_BIT_LAST);
  wire w_bskip = (op4 == ift_pkg::OP_BIT_SKIP_SET) ||
                 (op4 == ift_pkg::OP_BIT_SKIP_CLR);
  wire w_fskip = (ir[15:11] == ift_pkg::OP_CMP_SKIP) ||
                 ift_top6(ir, ift_pkg::OP_DEC_SKIP) ||
                 ift_top6(ir, ift_pkg::OP_INC_SKIP) ||
                 ift_top6(ir, ift_pkg::OP_INC_SKIPNZ) ||
                 ift_top6(ir, ift_pkg::OP_DEC_SKIPNZ);

  // Extended opcodes decode as no-ops while the extended set is off
  wire w_known = !(w_ext && !ext_enable);
  wire w_ext_on = w_ext && ext_enable;
  // Link-release forms of pointer add/sub also return from the routine
  wire w_unlink = w_ext_ptr && (ir[7:6] == 2'h3) && ext_enable;

  // Exactly four base two-word forms; the extended move pair adds more
  wire w_two = w_movff || w_goto || w_call || w_lfsr ||
               (w_ext_mov && ext_enable);
  wire w_skip = w_bskip || w_fskip;
  wire w_cond = w_skip || w_bcond;
  wire w_jump = w_rel || w_return || w_retfie || w_retlw || w_unlink ||
                (w_callw && ext_enable);

  // ****************************************************************
  // Class selection
  // ****************************************************************
  // Priority matters: the second-word tag and disabled extended codes
  // must win over every real class
  ift_pkg::ift_class_t raw_class;
  always_comb begin
    if (w_second || !w_known) begin
      raw_class = ift_pkg::IFT_CLASS_NOP;
    end else if (w_bit) begin
      raw_class = ift_pkg::IFT_CLASS_BIT;
    end else if (w_litop || w_movlb || w_lfsr ||
                 (w_ext_on && !w_ext_mov && !w_callw)) begin
      raw_class = ift_pkg::IFT_CLASS_LITERAL;
    end else if (w_rel || w_bcond || w_goto || w_call || w_misc ||
                 w_callw) begin
      raw_class = ift_pkg::IFT_CLASS_CONTROL;
    end else begin
      raw_class = ift_pkg::IFT_CLASS_BYTE;
    end
  end

  wire in_exec = (state == ift_pkg::IFT_EXEC);
  wire in_word2 = (state == ift_pkg::IFT_WORD2);
  wire is_nop = (raw_class == ift_pkg::IFT_CLASS_NOP);
  wire cls_byte = (raw_class == ift_pkg::IFT_CLASS_BYTE);
  wire cls_bit = (raw_class == ift_pkg::IFT_CLASS_BIT);

  // ****************************************************************
  // Cycle sequencing
  // ****************************************************************
  always_comb begin
    next_state = state;
    // cond_true is read only on the closing edge of a conditional word,
    // so the datapath has the whole cycle to settle its test
    case (state)
      ift_pkg::IFT_EXEC: begin
        if (w_known && w_two) begin
          next_state = ift_pkg::IFT_WORD2;
        end else if (w_known && w_skip && cond_true) begin
          next_state = ift_pkg::IFT_SKIP;
        end else if (w_known && (w_jump || (w_bcond && cond_true))) begin
          next_state = ift_pkg::IFT_FLUSH;
        end else begin
          next_state = ift_pkg::IFT_EXEC;
        end
      end
      ift_pkg::IFT_WORD2: begin
        next_state = ift_pkg::IFT_EXEC;
      end
      ift_pkg::IFT_SKIP: begin
        // A skipped two-word instruction drops its second word too
        if (w_known && w_two) begin
          next_state = ift_pkg::IFT_FLUSH;
        end else begin
          next_state = ift_pkg::IFT_EXEC;
        end
      end
      ift_pkg::IFT_FLUSH: begin
        next_state = ift_pkg::IFT_EXEC;
      end
      default: begin
        next_state = ift_pkg::IFT_EXEC;
      end
    endcase
  end

  // Word and state change only at the end of an instruction cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ift_pkg::IFT_EXEC;
    end else if (q_last) begin
      state <= next_state;
    end
  end

  // The word fetched during a first word's cycle is its second word
  wire load_second = q_last && in_exec && w_known && w_two;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ir <= ift_pkg::RESET_WORD;
    end else if (q_last && !load_second) begin
      ir <= instr_word;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ir2 <= ift_pkg::RESET_WORD;
    end else if (load_second) begin
      ir2 <= instr_word;
    end
  end

  // ****************************************************************
  // Timing outputs
  // ****************************************************************
  assign phase = q;
  assign cycle_end = q_last;
  // The program counter lives in the program memory: this block only says when
  // a word is taken and which taken words must be thrown away
  assign fetch_take = q_last;
  assign discard_cycle = (state == ift_pkg::IFT_SKIP) ||
                         (state == ift_pkg::IFT_FLUSH);
  assign exec_valid = (in_exec || in_word2) && !is_nop;
  assign nop_cycle = !exec_valid;

  // ****************************************************************
  // Operand fields
  // ****************************************************************
  // Discarded cycles report a no-op so the datapath does nothing
  assign op_class = discard_cycle ? ift_pkg::IFT_CLASS_NOP : raw_class;
  assign op_word = ir;
  assign two_word = w_two && w_known;
  assign instr_known = w_known;
  assign is_conditional = w_cond && w_known;
  assign changes_pc = w_known && (w_jump || w_goto || w_call);

  assign dest_file = cls_byte && ir[ift_pkg::DEST_BIT];
  assign bank_from_bsr = (cls_byte || cls_bit) &&
                         ir[ift_pkg::ACCESS_BIT];
  assign bit_sel = cls_bit ? ir[ift_pkg::BITSEL_LSB +: 3] : 3'h0;
  assign bit_mask = cls_bit ? (8'h01 << bit_sel) : 8'h00;
  // File and literal fields follow the word in discarded cycles as well;
  // consumers qualify them with op_class
  assign file_addr = ir[7:0];
  assign literal = ir[7:0];

  // Pointer select sits in different places for load and add forms
  assign pointer_sel = w_lfsr ? ir[5:4] :
                       (w_ext_ptr ? ir[7:6] : 2'h0);

  assign fast_mode = w_known &&
                     ((w_call && ir[ift_pkg::CALL_FAST_BIT]) ||
                      ((w_return || w_retfie) &&
                       ir[ift_pkg::RET_FAST_BIT]));
  assign table_write = w_table && ir[ift_pkg::TBL_WRITE_BIT];
  assign table_mode = w_table ? ir[1:0] : 2'h0;

  // ****************************************************************
  // Double-word operands
  // ****************************************************************
  // Operands of the pair are valid only during the second cycle
  always_comb begin
    long_operand = 20'h00000;
    dest_addr = 12'h000;
    if (in_word2) begin
      if (w_goto || w_call) begin
        long_operand = {ir2[11:0], ir[7:0]};
      end else if (w_lfsr) begin
        long_operand = {8'h00, ir[3:0], ir2[7:0]};
      end else begin
        long_operand = {8'h00, ir[11:0]};
        dest_addr = ir2[11:0];
      end
    end else if (w_rel) begin
      long_operand = {9'h000, ir[10:0]};
    end else if (w_bcond) begin
      long_operand = {12'h000, ir[7:0]};
    end
  end

endmodule : ift_decoder

// ### ift_prog_mem.sv
`timescale 1ns/100ps
module ift_prog_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fetch path
  input wire logic fetch_take,
  output logic [15:0] instr_word
);
  logic [15:0] mem [0:255];
  logic [7:0] pc;

  // Linear fetch keeps both halves of a pair in consecutive words
  assign instr_word = mem[pc];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= 8'h00;
    end else if (fetch_take) begin
      pc <= pc + 8'h01;
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
  end
endmodule : ift_prog_mem

// ### ift_decoder_properties.sv
`timescale 1ns/100ps
module ift_decoder_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Observed ports
  input wire logic fetch_take,
  input wire logic cond_true,
  input wire logic cycle_end,
  input wire logic [1:0] phase,
  input wire logic exec_valid,
  input wire logic nop_cycle,
  input wire logic discard_cycle,
  input wire ift_pkg::ift_class_t op_class,
  input wire logic [15:0] op_word,
  input wire logic two_word,
  input wire logic instr_known,
  input wire logic is_conditional,
  input wire logic changes_pc,
  input wire logic dest_file,
  input wire logic bank_from_bsr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] bit_mask
);
  // Marks the cycle holding the second half of a pair
  logic in_second;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_second <= 1'b0;
    end else if (fetch_take) begin
      in_second <= exec_valid && two_word && !in_second;
    end
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_period;
    fetch_take |=> !fetch_take [*3] ##1 fetch_take;
  endproperty
  a_period: assert property (p_period)
    else $error("fetch spacing wrong");
  property p_phase;
    cycle_end == fetch_take && fetch_take == (phase == ift_pkg::PHASE_LAST);
  endproperty
  a_phase: assert property (p_phase)
    else $error("fetch not in last phase");
  property p_nop;
    nop_cycle == (op_class == ift_pkg::IFT_CLASS_NOP);
  endproperty
  a_nop: assert property (p_nop)
    else $error("nop flag disagrees");
  property p_stand;
    !fetch_take |=> $stable(op_word);
  endproperty
  a_stand: assert property (p_stand)
    else $error("word changed mid cycle");
  property p_discard;
    discard_cycle |-> op_class == ift_pkg::IFT_CLASS_NOP && !exec_valid;
  endproperty
  a_discard: assert property (p_discard)
    else $error("discarded word acts");
  property p_lone;
    op_word[15:12] == ift_pkg::SECOND_WORD_TAG
      |-> op_class == ift_pkg::IFT_CLASS_NOP;
  endproperty
  a_lone: assert property (p_lone)
    else $error("lone second word acts");
  property p_bit;
    op_class == ift_pkg::IFT_CLASS_BIT
      |-> bit_sel == op_word[11:9] && bit_mask == (8'h01 << bit_sel);
  endproperty
  a_bit: assert property (p_bit)
    else $error("bit select wrong");
  property p_byte;
    op_class == ift_pkg::IFT_CLASS_BYTE && op_word[15:13] == 3'h1
      |-> dest_file == op_word[9] && bank_from_bsr == op_word[8];
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte fields wrong");
  property p_flush;
    fetch_take && exec_valid && changes_pc && !is_conditional && !two_word
      |=> discard_cycle;
  endproperty
  a_flush: assert property (p_flush)
    else $error("no flush after jump");
  property p_taken;
    fetch_take && exec_valid && is_conditional && cond_true |=> discard_cycle;
  endproperty
  a_taken: assert property (p_taken)
    else $error("no discard after true test");
  property p_pair;
    fetch_take && exec_valid && two_word && !in_second
      |=> exec_valid && two_word && !discard_cycle;
  endproperty
  a_pair: assert property (p_pair)
    else $error("pair not two cycles");
  property p_known;
    !instr_known |-> op_class == ift_pkg::IFT_CLASS_NOP;
  endproperty
  a_known: assert property (p_known)
    else $error("unknown word acts");
endmodule : ift_decoder_checker

bind ift_decoder ift_decoder_checker u_ift_decoder_checker (
  .clk(clk), .reset_n(reset_n), .fetch_take(fetch_take),
  .cond_true(cond_true), .cycle_end(cycle_end), .phase(phase),
  .exec_valid(exec_valid), .nop_cycle(nop_cycle),
  .discard_cycle(discard_cycle), .op_class(op_class), .op_word(op_word),
  .two_word(two_word), .instr_known(instr_known),
  .is_conditional(is_conditional), .changes_pc(changes_pc),
  .dest_file(dest_file), .bank_from_bsr(bank_from_bsr),
  .bit_sel(bit_sel), .bit_mask(bit_mask));

// ### tb_instruction_format_timing.sv
`timescale 1ns/100ps
module tb_instruction_format_timing;
  logic clk, reset_n, cond_true, ext_enable;
  logic fetch_take, cycle_end, exec_valid, nop_cycle, discard_cycle;
  logic two_word, instr_known, is_conditional, changes_pc, dest_file;
  logic bank_from_bsr, fast_mode, table_write;
  logic [1:0] phase, pointer_sel, table_mode;
  logic [2:0] bit_sel;
  logic [7:0] bit_mask, file_addr, literal;
  logic [11:0] dest_addr;
  logic [15:0] instr_word, op_word;
  logic [19:0] long_operand;
  ift_pkg::ift_class_t op_class;
  int err_count, n_checks;

  ift_prog_mem u_ift_prog_mem (.clk, .reset_n, .fetch_take, .instr_word);
  ift_decoder u_ift_decoder (.clk, .reset_n, .instr_word, .fetch_take,
    .cond_true, .ext_enable, .phase, .cycle_end, .exec_valid, .nop_cycle,
    .discard_cycle, .op_class, .op_word, .two_word, .instr_known,
    .is_conditional, .changes_pc, .dest_file, .bank_from_bsr, .bit_sel,
    .bit_mask, .file_addr, .literal, .pointer_sel, .fast_mode,
    .table_write, .table_mode, .long_operand, .dest_addr);

  always #5 clk = ~clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic conclude();
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cls(input ift_pkg::ift_class_t e);
    chk(20'(op_class), 20'(e));
  endtask : cls

  task automatic dsc(input logic e);
    chk(20'(discard_cycle), 20'(e));
  endtask : dsc

  // Entered at phase 0, leaves at phase 0 of the next cycle
  task automatic step();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (fetch_take !== 1'b1 && n < 8);
    chk(20'(n), 20'h3);
    @(negedge clk);
    chk(20'(phase), 20'h0);
  endtask : step

  // Word 0 lands in the instruction cycle after the current one, word i i cycles after that
  task automatic put(input int i, input logic [15:0] w);
    u_ift_prog_mem.mem[u_ift_prog_mem.pc + 8'(i)] = w;
  endtask : put

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_fields();
    put(0, 16'h2655);
    put(1, 16'h2555);
    put(2, 16'h8b12);
    put(3, 16'h0e5a);
    step();
    cls(ift_pkg::IFT_CLASS_BYTE);
    chk(20'(dest_file), 20'h1);
    chk(20'(bank_from_bsr), 20'h0);
    chk(20'(file_addr), 20'h55);
    chk(20'(op_word), 20'h2655);
    chk(20'(changes_pc), 20'h0);
    step();
    chk(20'({dest_file, bank_from_bsr}), 20'h1);
    step();
    cls(ift_pkg::IFT_CLASS_BIT);
    chk(20'(bit_sel), 20'h5);
    chk(20'(bit_mask), 20'h20);
    chk(20'(file_addr), 20'h12);
    step();
    cls(ift_pkg::IFT_CLASS_LITERAL);
    chk(20'(literal), 20'h5a);
  endtask : t_fields

  task automatic t_table();
    for (int i = 0; i < 8; i++) begin
      put(i, 16'h0008 + 16'(i));
    end
    for (int i = 0; i < 8; i++) begin
      step();
      cls(ift_pkg::IFT_CLASS_CONTROL);
      chk(20'(table_mode), 20'(i % 4));
      chk(20'(table_write), 20'(i / 4));
    end
  endtask : t_table

  task automatic t_pairs();
    put(0, 16'hef34);
    put(1, 16'hf123);
    put(2, 16'hed12);
    put(3, 16'hf001);
    put(4, 16'hee2a);
    put(5, 16'hf0bc);
    put(6, 16'hc123);
    put(7, 16'hf456);
    step();
    chk(20'({two_word, exec_valid}), 20'h3);
    step();
    chk(long_operand, 20'h12334);
    dsc(1'b0);
    step();
    dsc(1'b0);
    chk(20'(fast_mode), 20'h1);
    step();
    chk(long_operand, 20'h00112);
    step();
    step();
    chk(20'(pointer_sel), 20'h2);
    chk(long_operand, 20'h00abc);
    step();
    step();
    chk(long_operand, 20'h00123);
    chk(20'(dest_addr), 20'h456);
    step();
    chk(20'({two_word, discard_cycle}), 20'h0);
  endtask : t_pairs

  task automatic t_flow();
    put(0, 16'hd005);
    put(1, 16'h2655);
    put(2, 16'h0012);
    put(3, 16'h2655);
    put(4, 16'h0013);
    put(5, 16'h2655);
    put(6, 16'he003);
    put(7, 16'h0e11);
    put(8, 16'he003);
    put(9, 16'h2655);
    put(10, 16'hf000);
    step();
    chk(long_operand, 20'h00005);
    chk(20'(changes_pc), 20'h1);
    step();
    dsc(1'b1);
    cls(ift_pkg::IFT_CLASS_NOP);
    step();
    chk(20'(fast_mode), 20'h0);
    step();
    dsc(1'b1);
    step();
    chk(20'(fast_mode), 20'h1);
    step();
    step();
    chk(20'(is_conditional), 20'h1);
    step();
    dsc(1'b0);
    chk(20'(literal), 20'h11);
    step();
    cond_true = 1'b1;
    step();
    cond_true = 1'b0;
    dsc(1'b1);
    step();
    cls(ift_pkg::IFT_CLASS_NOP);
  endtask : t_flow

  task automatic t_skip();
    put(0, 16'hb012);
    put(1, 16'hef34);
    put(2, 16'hf123);
    put(3, 16'h0e77);
    step();
    cond_true = 1'b1;
    step();
    cond_true = 1'b0;
    dsc(1'b1);
    step();
    dsc(1'b1);
    step();
    dsc(1'b0);
    chk(20'(literal), 20'h77);
  endtask : t_skip

  task automatic t_ext();
    put(0, 16'h0014);
    put(1, 16'h0e01);
    put(2, 16'h0014);
    put(3, 16'h2655);
    put(4, 16'he8c5);
    step();
    chk(20'(instr_known), 20'h0);
    step();
    dsc(1'b0);
    ext_enable = 1'b1;
    step();
    chk(20'(instr_known), 20'h1);
    step();
    dsc(1'b1);
    step();
    chk(20'(pointer_sel), 20'h3);
  endtask : t_ext

  task automatic t_misc();
    put(0, 16'h0000);
    put(1, 16'h0c42);
    put(2, 16'h2655);
    put(3, 16'h0105);
    put(4, 16'h0011);
    put(5, 16'h2655);
    put(6, 16'h2e55);
    put(7, 16'h0e33);
    put(8, 16'heb05);
    put(9, 16'hf123);
    put(10, 16'h7a12);
    step();
    dsc(1'b1);
    step();
    chk(20'(literal), 20'h42);
    chk(20'(changes_pc), 20'h1);
    step();
    dsc(1'b1);
    step();
    cls(ift_pkg::IFT_CLASS_LITERAL);
    chk(20'(literal), 20'h05);
    step();
    chk(20'(fast_mode), 20'h1);
    step();
    dsc(1'b1);
    step();
    chk(20'(is_conditional), 20'h1);
    cond_true = 1'b1;
    step();
    cond_true = 1'b0;
    dsc(1'b1);
    step();
    chk(20'({two_word, exec_valid}), 20'h3);
    step();
    chk(long_operand, 20'h00b05);
    chk(20'(dest_addr), 20'h123);
    step();
    cls(ift_pkg::IFT_CLASS_BIT);
    chk(20'(bit_mask), 20'h20);
  endtask : t_misc

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    cond_true = 1'b0;
    ext_enable = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (12) @(negedge clk);
    chk(20'({exec_valid, fetch_take}), 20'h2);
    reset_n = 1'b1;
    t_fields();
    t_table();
    t_pairs();
    t_flow();
    t_skip();
    t_ext();
    t_misc();
    conclude();
  end

  initial begin
    #20000;
    err_count++;
    conclude();
  end
endmodule : tb_instruction_format_timing
